/* File: hw/fdcfg_pkg.sv */
package fdcfg_pkg;

    // ----------------------------------------------------------------
    // register indices
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_MODE   = 8'hF0;
    localparam logic [7:0] IDX_OPTION = 8'hF1;
    localparam logic [7:0] IDX_DTYPE  = 8'hF2;
    localparam logic [7:0] IDX_RSVD   = 8'hF3;
    localparam logic [7:0] IDX_DRV0   = 8'hF4;
    localparam logic [7:0] IDX_DRV1   = 8'hF5;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_MODE   = 8'h0E;
    localparam logic [7:0] RST_OPTION = 8'h00;
    localparam logic [7:0] RST_DTYPE  = 8'hFF;
    localparam logic [7:0] RST_DRV    = 8'h00;

    // ----------------------------------------------------------------
    // writable bit masks
    // ----------------------------------------------------------------
    localparam logic [7:0] WMASK_MODE   = 8'hCF;
    localparam logic [7:0] WMASK_OPTION = 8'h0D;
    localparam logic [7:0] WMASK_DTYPE  = 8'hFF;
    localparam logic [7:0] WMASK_DRV    = 8'h5B;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int MODE_ENH_BIT     = 0;
    localparam int MODE_NOBURST_BIT = 1;
    localparam int MODE_IF_LO       = 2;
    localparam int MODE_PUSHPULL    = 6;
    localparam int MODE_TRISTATE    = 7;
    localparam int OPT_FWP_BIT      = 0;
    localparam int OPT_DENS_LO      = 2;
    localparam int DRV_TYPE_LO      = 0;
    localparam int DRV_RATE_LO      = 3;
    localparam int DRV_PRECOMP_BIT  = 6;

    // ----------------------------------------------------------------
    // encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] IFM_AT      = 2'b11;
    localparam logic [1:0] DENS_FORCE1 = 2'b10;
    localparam logic [1:0] DENS_FORCE0 = 2'b11;

    typedef enum logic [2:0] {
        ECP_PRINTER = 3'b000, ECP_SPP = 3'b001, ECP_FIFO = 3'b010, ECP_ECP = 3'b011,
        ECP_EPP = 3'b100, ECP_RES = 3'b101, ECP_TEST = 3'b110, ECP_CONFIG = 3'b111
    } fdcfg_ecp_mode_e;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } fdcfg_bus_s;

    typedef struct packed {
        logic       enhanced_mode;
        logic       non_burst_dma;
        logic [1:0] if_mode;
        logic       push_pull;
        logic       tristate;
        logic [1:0] type_a;
        logic [1:0] type_b;
        logic [1:0] drv0_type;
        logic [1:0] drv0_rate;
        logic       drv0_no_precomp;
        logic [1:0] drv1_type;
        logic [1:0] drv1_rate;
        logic       drv1_no_precomp;
    } fdcfg_cfg_s;

    typedef struct packed {
        logic req;
        logic ack;
    } fdcfg_line_s;

endpackage

/* File: hw/fdcfg_top.sv */
// Notes on behaviour
// (RULE1) device-local bits also disable irq/dack
// (RULE2) fdc dma-enable low floats irq/dack, ignores dreq
// (RULE3) fdc powered down: irq/dack high impedance
// (RULE4) uart aux output two low floats irq
// (RULE5) spp/epp: parallel irq enable gates irq
// (RULE6) ecp: dma enable gates dreq; mode-coded irq
// (RULE7) registers reset only on hard reset
// (RULE8) mode bit0 enhanced floppy, bit1 non-burst
// (RULE9) mode bits 3:2 interface personality
// (RULE10) mode bit6 push-pull else open drain
// (RULE11) mode bit7 tristates fdc pins, not pp
// (RULE12) forced write protect on drive 0 select
// (RULE13) forced write protect also on pp floppy
// (RULE14) option bits 3:2 density override
// (RULE15) drive-type store, resets to FF
// (RULE16) index F3 reads zero
// (RULE17) drive 0 type, rate, precomp fields
// (RULE18) drive 1 same layout as drive 0
// (RULE19) drive 0 is always boot drive
// (RULE20) unused irq pins held high impedance
// (RULE21) effects next cycle, reserved bits ignore writes; option writes reach density_o and write protect one cycle after that
//
// Local design decision: strobed register access.
`timescale 1ns/1ns

module fdcfg_top
    import fdcfg_pkg::*;
(
    // clock and hard reset
    input  wire logic        core_clk,
    input  wire logic        rst,

    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,

    // configuration-level enables
    input  wire logic        fdc_cfg_ok,
    input  wire logic        uart1_cfg_ok,
    input  wire logic        uart2_cfg_ok,
    input  wire logic        pp_cfg_ok,

    // floppy local controls
    input  wire logic        floppy_dma_irq_enable,
    input  wire logic        fdc_powered_down,
    input  wire logic        fdc_irq,
    input  wire logic        fdc_dreq,
    input  wire logic        fdc_dack_n,
    output logic             fdc_dreq_core,

    // serial port local controls
    input  wire logic        uart1_aux_output_two,
    input  wire logic        uart2_aux_output_two,
    input  wire logic        uart1_irq,
    input  wire logic        uart2_irq,

    // parallel port local controls
    input  wire logic        pp_ecp_active,
    input  wire logic [2:0]  pp_ecp_mode,
    input  wire logic        parallel_irq_enable,
    input  wire logic        ext_port_dma_enable,
    input  wire logic        pp_irq,
    input  wire logic        pp_dreq,

    // gated host lines: value and output enable
    output logic             fdc_irq_o,
    output logic             fdc_irq_oe,
    output logic             fdc_dack_n_o,
    output logic             fdc_dack_oe,
    output logic             uart1_irq_o,
    output logic             uart1_irq_oe,
    output logic             uart2_irq_o,
    output logic             uart2_irq_oe,
    output logic             pp_irq_o,
    output logic             pp_irq_oe,
    output logic             pp_dreq_o,
    output logic             pp_dreq_oe,

    // floppy drive interface
    input  wire logic        write_protect_n,
    input  wire logic        pp_write_protect_n,
    input  wire logic        drive_select0_n,
    input  wire logic        pp_drive_select0_n,
    input  wire logic        core_density,
    output logic             core_write_protect_n,
    output logic             core_pp_write_protect_n,
    output logic             density_o,
    output logic             fdc_pins_oe,
    output logic             fdc_pins_push_pull,
    output logic             boot_drive,
    output fdcfg_cfg_s       cfg
);

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    logic [7:0] mode_q;
    logic [7:0] option_q;
    logic [7:0] dtype_q;
    logic [7:0] drv0_q;
    logic [7:0] drv1_q;
    fdcfg_bus_s bus;

    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    function automatic logic [7:0] merge(input logic [7:0] old_v,
                                         input logic [7:0] new_v,
                                         input logic [7:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    function automatic logic wr_hit(input fdcfg_bus_s b, input logic [7:0] idx);
        wr_hit = b.wr && (b.addr == idx);
    endfunction

    // rst is the hard reset only; soft resets never reach here
    always_ff @(posedge core_clk) begin
        if (rst) begin // [RULE7]
            mode_q <= RST_MODE;
        end else if (wr_hit(bus, IDX_MODE)) begin
            mode_q <= merge(mode_q, bus.wdata, WMASK_MODE); // [RULE8] [RULE9] [RULE21]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin // [RULE7]
            option_q <= RST_OPTION;
        end else if (wr_hit(bus, IDX_OPTION)) begin
            option_q <= merge(option_q, bus.wdata, WMASK_OPTION); // [RULE21]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin // [RULE7]
            dtype_q <= RST_DTYPE; // [RULE15]
        end else if (wr_hit(bus, IDX_DTYPE)) begin
            dtype_q <= merge(dtype_q, bus.wdata, WMASK_DTYPE); // [RULE15]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin // [RULE7]
            drv0_q <= RST_DRV;
        end else if (wr_hit(bus, IDX_DRV0)) begin
            drv0_q <= merge(drv0_q, bus.wdata, WMASK_DRV); // [RULE17]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin // [RULE7]
            drv1_q <= RST_DRV;
        end else if (wr_hit(bus, IDX_DRV1)) begin
            drv1_q <= merge(drv1_q, bus.wdata, WMASK_DRV); // [RULE18]
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    logic [7:0] rdata_d;

    always_comb begin
        case (bus.addr)
            IDX_MODE:   rdata_d = mode_q;
            IDX_OPTION: rdata_d = option_q;
            IDX_DTYPE:  rdata_d = dtype_q;
            IDX_RSVD:   rdata_d = 8'h00; // [RULE16]
            IDX_DRV0:   rdata_d = drv0_q & WMASK_DRV; // [RULE17]
            IDX_DRV1:   rdata_d = drv1_q & WMASK_DRV; // [RULE18]
            default:    rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (bus.rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // configuration outputs
    // ----------------------------------------------------------------
    always_comb begin
        cfg.enhanced_mode   = mode_q[MODE_ENH_BIT]; // [RULE8]
        cfg.non_burst_dma   = mode_q[MODE_NOBURST_BIT]; // [RULE8]
        cfg.if_mode         = mode_q[MODE_IF_LO +: 2]; // [RULE9]
        cfg.push_pull       = mode_q[MODE_PUSHPULL];
        cfg.tristate        = mode_q[MODE_TRISTATE];

        cfg.type_a          = dtype_q[1:0];
        cfg.type_b          = dtype_q[3:2];

        cfg.drv0_type       = drv0_q[DRV_TYPE_LO +: 2]; // [RULE17]
        cfg.drv0_rate       = drv0_q[DRV_RATE_LO +: 2];
        cfg.drv0_no_precomp = drv0_q[DRV_PRECOMP_BIT];
        cfg.drv1_type       = drv1_q[DRV_TYPE_LO +: 2]; // [RULE18]
        cfg.drv1_rate       = drv1_q[DRV_RATE_LO +: 2];
        cfg.drv1_no_precomp = drv1_q[DRV_PRECOMP_BIT];
    end

    assign boot_drive         = 1'b0; // [RULE19]
    assign fdc_pins_push_pull = mode_q[MODE_PUSHPULL]; // [RULE10]
    assign fdc_pins_oe        = ~mode_q[MODE_TRISTATE]; // [RULE11]

    // ----------------------------------------------------------------
    // floppy drive lines
    // ----------------------------------------------------------------
    // active-low write protect is forced low while drive 0 selected
    logic force_write_protect;
    assign force_write_protect = option_q[OPT_FWP_BIT];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            core_write_protect_n <= 1'b1;
        end else begin
            core_write_protect_n <= write_protect_n
                & ~(force_write_protect & ~drive_select0_n); // [RULE12]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            core_pp_write_protect_n <= 1'b1;
        end else begin
            core_pp_write_protect_n <= pp_write_protect_n
                & ~(force_write_protect & ~pp_drive_select0_n); // [RULE13]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            density_o <= 1'b0;
        end else begin
            case (option_q[OPT_DENS_LO +: 2]) // [RULE14]
                DENS_FORCE1: density_o <= 1'b1;
                DENS_FORCE0: density_o <= 1'b0;
                default:     density_o <= core_density;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // interrupt and dma gating
    // ----------------------------------------------------------------
    function automatic logic ecp_irq_forced(input logic [2:0] m);
        case (m)
            ECP_FIFO, ECP_ECP, ECP_TEST: ecp_irq_forced = 1'b1;
            default:                     ecp_irq_forced = 1'b0;
        endcase
    endfunction

    logic fdc_en;
    logic uart1_en;
    logic uart2_en;
    logic pp_irq_en;
    logic pp_dma_en;

    // disabled lines float; the pin oe is the enable registered one cycle later
    assign fdc_en = fdc_cfg_ok & floppy_dma_irq_enable & ~fdc_powered_down; // [RULE1] [RULE2] [RULE3]
    assign uart1_en = uart1_cfg_ok & uart1_aux_output_two; // [RULE4] [RULE1]
    assign uart2_en = uart2_cfg_ok & uart2_aux_output_two; // [RULE4] [RULE1]
    assign pp_irq_en = pp_cfg_ok & (pp_ecp_active
        ? (ecp_irq_forced(pp_ecp_mode) | parallel_irq_enable) // [RULE6]
        : parallel_irq_enable); // [RULE5]
    assign pp_dma_en = pp_cfg_ok & pp_ecp_active & ext_port_dma_enable; // [RULE6]

    always_ff @(posedge core_clk) begin
        if (rst) begin // [RULE20]
            fdc_irq_oe <= 1'b0;
        end else begin
            fdc_irq_oe <= fdc_en; // [RULE1] [RULE2] [RULE3]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            fdc_irq_o <= 1'b0;
        end else begin
            fdc_irq_o <= fdc_irq & fdc_en;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin // [RULE20]
            fdc_dack_oe <= 1'b0;
        end else begin
            fdc_dack_oe <= fdc_en; // [RULE2] [RULE3]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            fdc_dack_n_o <= 1'b1;
        end else begin
            fdc_dack_n_o <= fdc_dack_n | ~fdc_en;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            fdc_dreq_core <= 1'b0;
        end else begin
            fdc_dreq_core <= fdc_dreq & fdc_en; // [RULE2]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin // [RULE20]
            uart1_irq_oe <= 1'b0;
        end else begin
            uart1_irq_oe <= uart1_en; // [RULE4]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            uart1_irq_o <= 1'b0;
        end else begin
            uart1_irq_o <= uart1_irq & uart1_en;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin // [RULE20]
            uart2_irq_oe <= 1'b0;
        end else begin
            uart2_irq_oe <= uart2_en; // [RULE4]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            uart2_irq_o <= 1'b0;
        end else begin
            uart2_irq_o <= uart2_irq & uart2_en;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin // [RULE20]
            pp_irq_oe <= 1'b0;
        end else begin
            pp_irq_oe <= pp_irq_en; // [RULE5] [RULE6]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pp_irq_o <= 1'b0;
        end else begin
            pp_irq_o <= pp_irq & pp_irq_en;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin // [RULE20]
            pp_dreq_oe <= 1'b0;
        end else begin
            pp_dreq_oe <= pp_dma_en; // [RULE6]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pp_dreq_o <= 1'b0;
        end else begin
            pp_dreq_o <= pp_dreq & pp_dma_en;
        end
    end

endmodule // fdcfg_top

/* File: testbench/fdcfg_host_model.sv */
`timescale 1ns/1ns
module fdcfg_host_model (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // dma handshake
    input  wire logic fdc_dreq,
    output logic      fdc_dack_n,
    // device line pairs
    input  wire logic fdc_irq_o,
    input  wire logic fdc_irq_oe,
    input  wire logic fdc_dack_n_o,
    input  wire logic fdc_dack_oe,
    input  wire logic uart1_irq_o,
    input  wire logic uart1_irq_oe,
    input  wire logic uart2_irq_o,
    input  wire logic uart2_irq_oe,
    input  wire logic pp_irq_o,
    input  wire logic pp_irq_oe,
    input  wire logic pp_dreq_o,
    input  wire logic pp_dreq_oe,
    // resolved board lines
    output logic      fdc_irq_w,
    output logic      fdc_dack_w,
    output logic      uart1_irq_w,
    output logic      uart2_irq_w,
    output logic      pp_irq_w,
    output logic      pp_dreq_w
);
    // host grants a pending request one cycle later
    always_ff @(posedge core_clk) begin
        fdc_dack_n <= rst | ~fdc_dreq;
    end
    // released lines fall to the board pulls
    assign fdc_irq_w   = fdc_irq_oe ? fdc_irq_o : 1'b0;
    assign fdc_dack_w  = fdc_dack_oe ? fdc_dack_n_o : 1'b1;
    assign uart1_irq_w = uart1_irq_oe ? uart1_irq_o : 1'b0;
    assign uart2_irq_w = uart2_irq_oe ? uart2_irq_o : 1'b0;
    assign pp_irq_w    = pp_irq_oe ? pp_irq_o : 1'b0;
    assign pp_dreq_w   = pp_dreq_oe ? pp_dreq_o : 1'b0;
endmodule // fdcfg_host_model

/* File: testbench/fdcfg_monitor.sv */
`timescale 1ns/1ns
module fdcfg_monitor
    import fdcfg_pkg::*;
(
    // clock and register port
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // gating
    input wire logic       fdc_cfg_ok,
    input wire logic       floppy_dma_irq_enable,
    input wire logic       fdc_powered_down,
    input wire logic       fdc_irq_oe,
    input wire logic       fdc_dack_oe,
    input wire logic       uart1_aux_output_two,
    input wire logic       uart1_irq_oe,
    input wire logic       pp_cfg_ok,
    input wire logic       pp_ecp_active,
    input wire logic       parallel_irq_enable,
    input wire logic       ext_port_dma_enable,
    input wire logic       pp_irq_oe,
    input wire logic       pp_dreq_oe,
    // floppy pins
    input wire logic       write_protect_n,
    input wire logic       core_write_protect_n,
    input wire logic       fdc_pins_oe,
    input wire logic       fdc_pins_push_pull
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_mode_wr;
        reg_wr && reg_addr == IDX_MODE;
    endsequence
    sequence s_fdc_off;
        !fdc_cfg_ok || !floppy_dma_irq_enable || fdc_powered_down;
    endsequence

    property p_mode_pins;
        s_mode_wr |=> fdc_pins_oe == !$past(reg_wdata[7])
            && fdc_pins_push_pull == $past(reg_wdata[6]);
    endproperty
    a_mode_pins: assert property (p_mode_pins)
        else $error("floppy pin drive mismatch");

    property p_rsvd_rd;
        reg_rd && reg_addr == IDX_RSVD |=> reg_rdata == 8'h00;
    endproperty
    a_rsvd_rd: assert property (p_rsvd_rd)
        else $error("reserved index read nonzero");

    property p_rd_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read slot");

    property p_fdc_off;
        s_fdc_off |=> !fdc_irq_oe && !fdc_dack_oe;
    endproperty
    a_fdc_off: assert property (p_fdc_off)
        else $error("floppy lines driven while gated");

    property p_uart;
        !uart1_aux_output_two |=> !uart1_irq_oe;
    endproperty
    a_uart: assert property (p_uart)
        else $error("serial irq driven while gated");

    property p_spp;
        pp_cfg_ok && !pp_ecp_active |=> pp_irq_oe == $past(parallel_irq_enable) && !pp_dreq_oe;
    endproperty
    a_spp: assert property (p_spp)
        else $error("parallel irq gating wrong");

    property p_ecp;
        pp_cfg_ok && pp_ecp_active |=> pp_dreq_oe == $past(ext_port_dma_enable);
    endproperty
    a_ecp: assert property (p_ecp)
        else $error("parallel dreq gating wrong");

    property p_wp;
        !write_protect_n |=> !core_write_protect_n;
    endproperty
    a_wp: assert property (p_wp)
        else $error("write protect not passed");
endmodule // fdcfg_monitor

bind fdcfg_top fdcfg_monitor u_mon (
    .core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .fdc_cfg_ok, .floppy_dma_irq_enable, .fdc_powered_down, .fdc_irq_oe, .fdc_dack_oe,
    .uart1_aux_output_two, .uart1_irq_oe, .pp_cfg_ok, .pp_ecp_active,
    .parallel_irq_enable, .ext_port_dma_enable, .pp_irq_oe, .pp_dreq_oe,
    .write_protect_n, .core_write_protect_n, .fdc_pins_oe, .fdc_pins_push_pull
);

/* File: testbench/test_fdc_config_and_irq_dma_gating.sv */
`timescale 1ns/1ns
module test_fdc_config_and_irq_dma_gating
    import fdcfg_pkg::*;
;
    // ----------
    // signals
    // ----------
    logic       core_clk, rst, reg_wr, reg_rd, fdc_dack_n, fdc_dreq_core;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, sn;
    logic       fdc_cfg_ok, uart1_cfg_ok, uart2_cfg_ok, pp_cfg_ok;
    logic       floppy_dma_irq_enable, fdc_powered_down, fdc_irq, fdc_dreq;
    logic       uart1_aux_output_two, uart2_aux_output_two, uart1_irq, uart2_irq;
    logic       pp_ecp_active, parallel_irq_enable, ext_port_dma_enable, pp_irq, pp_dreq;
    logic [2:0] pp_ecp_mode;
    logic       fdc_irq_o, fdc_irq_oe, fdc_dack_n_o, fdc_dack_oe, uart1_irq_o, uart1_irq_oe;
    logic       uart2_irq_o, uart2_irq_oe, pp_irq_o, pp_irq_oe, pp_dreq_o, pp_dreq_oe;
    logic       write_protect_n, pp_write_protect_n, drive_select0_n, pp_drive_select0_n;
    logic       core_density, core_write_protect_n, core_pp_write_protect_n, density_o;
    logic       fdc_pins_oe, fdc_pins_push_pull, boot_drive;
    logic       fdc_irq_w, fdc_dack_w, uart1_irq_w, uart2_irq_w, pp_irq_w, pp_dreq_w;
    fdcfg_cfg_s cfg;
    int         fails, cmp_count, cyc;
    logic [7:0] idx [7] = '{8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'h10};
    logic [7:0] rv  [7] = '{8'h0E, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] mk  [7] = '{8'hCF, 8'h0D, 8'hFF, 8'h00, 8'h5B, 8'h5B, 8'h00};

    fdcfg_top uut (.*);
    fdcfg_host_model u_host (.*);

    // ----------
    // tasks
    // ----------
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk("rdata", reg_rdata, e);
    endtask
    task automatic settle;
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ----------
    // sequence
    // ----------
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            end_of_test();
        end
    end
    initial begin
        logic ie, de;
        {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'h4, 16'h0};
        {fdc_cfg_ok, uart1_cfg_ok, uart2_cfg_ok, pp_cfg_ok} = 4'hF;
        {floppy_dma_irq_enable, fdc_powered_down, fdc_irq, fdc_dreq} = 4'hB;
        {uart1_aux_output_two, uart2_aux_output_two, uart1_irq, uart2_irq} = 4'hF;
        {pp_ecp_active, parallel_irq_enable, ext_port_dma_enable, pp_irq, pp_dreq} = 5'h03;
        pp_ecp_mode = 3'h0;
        {write_protect_n, pp_write_protect_n, drive_select0_n, pp_drive_select0_n} = 4'hF;
        core_density = 1'b0;
        {fails, cmp_count, cyc} = '0;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        foreach (idx[i]) rd(idx[i], rv[i]);
        foreach (idx[i]) wr(idx[i], 8'hFF);
        foreach (idx[i]) rd(idx[i], mk[i]);
        @(posedge core_clk);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        foreach (idx[i]) rd(idx[i], rv[i]);
        for (int m = 0; m < 4; m++) begin
            wr(IDX_MODE, 8'(m << 2) | (m[0] ? 8'h82 : 8'h41));
            settle();
            chk("if_mode", {6'h0, cfg.if_mode}, 8'(m));
            sn = {3'h0, cfg.tristate, fdc_pins_oe, fdc_pins_push_pull, cfg.enhanced_mode,
                  cfg.non_burst_dma};
            chk("mode", sn, m[0] ? 8'h11 : 8'h0E);
        end
        wr(IDX_DRV0, 8'h53);
        wr(IDX_DRV1, 8'h0A);
        wr(IDX_DTYPE, 8'h36);
        settle();
        chk("drv0", {3'h0, cfg.drv0_no_precomp, cfg.drv0_rate, cfg.drv0_type}, 8'h1B);
        chk("drv1", {3'h0, cfg.drv1_no_precomp, cfg.drv1_rate, cfg.drv1_type}, 8'h06);
        chk("boot", {7'h0, boot_drive}, 8'h00);
        chk("dtype", {4'h0, cfg.type_b, cfg.type_a}, 8'h06);
        wr(IDX_OPTION, 8'h01);
        for (int k = 0; k < 4; k++) begin
            @(posedge core_clk);
            {write_protect_n, drive_select0_n} <= 2'(k);
            {pp_write_protect_n, pp_drive_select0_n} <= 2'(k);
            settle();
            sn = {6'h0, core_write_protect_n, core_pp_write_protect_n};
            chk("wp", sn, (k == 3) ? 8'h03 : 8'h00);
        end
        for (int k = 0; k < 8; k++) begin
            wr(IDX_OPTION, {4'h0, k[2:1], 2'h0});
            core_density <= k[0];
            settle();
            ie = (k[2:1] == 2) ? 1'b1 : (k[2:1] == 3) ? 1'b0 : k[0];
            chk("density", {7'h0, density_o}, {7'h0, ie});
        end
        @(posedge core_clk);
        {drive_select0_n, pp_drive_select0_n} <= 2'b00;
        settle();
        sn = {6'h0, core_write_protect_n, core_pp_write_protect_n};
        chk("wp_off", sn, 8'h03);
        for (int k = 0; k < 8; k++) begin
            @(posedge core_clk);
            {fdc_cfg_ok, floppy_dma_irq_enable, fdc_powered_down} <= 3'(k);
            settle();
            ie = (k == 6);
            sn = {3'h0, fdc_irq_oe, fdc_dack_oe, fdc_irq_w, fdc_dack_w, fdc_dreq_core};
            chk("fdc", sn, {3'h0, ie, ie, ie, !ie, ie});
        end
        for (int k = 0; k < 4; k++) begin
            @(posedge core_clk);
            {uart1_cfg_ok, uart1_aux_output_two} <= 2'(k);
            {uart2_cfg_ok, uart2_aux_output_two} <= 2'(k);
            settle();
            sn = {4'h0, uart1_irq_oe, uart1_irq_w, uart2_irq_oe, uart2_irq_w};
            chk("uart", sn, (k == 3) ? 8'h0F : 8'h00);
        end
        for (int k = 0; k < 32; k++) begin
            @(posedge core_clk);
            {pp_ecp_active, parallel_irq_enable, pp_ecp_mode} <= 5'(k);
            ext_port_dma_enable <= k[0] ^ k[3];
            settle();
            ie = k[3] | (k[4] & (k[2:0] inside {3'h2, 3'h3, 3'h6}));
            de = k[4] & (k[0] ^ k[3]);
            sn = {4'h0, pp_irq_oe, pp_irq_w, pp_dreq_oe, pp_dreq_w};
            chk("pp", sn, {4'h0, ie, ie, de, de});
        end
        @(posedge core_clk);
        pp_cfg_ok <= 1'b0;
        ext_port_dma_enable <= 1'b1;
        settle();
        sn = {4'h0, pp_irq_oe, pp_irq_w, pp_dreq_oe, pp_dreq_w};
        chk("pp_off", sn, 8'h00);
        end_of_test();
    end
endmodule // test_fdc_config_and_irq_dma_gating
